/* File: dv/rdsw_host_mem.sv */
// rdsw_host_mem.sv: host memory model behind the descriptor word write.
// assumes: one word write at a time, same clock as the block.
`timescale 1ns/10ps
`default_nettype none
module rdsw_host_mem (
   // clock and reset
   input wire logic core_clk,
   input wire logic sys_rst,
   // pacing and word port
   input wire logic hostSlow,
   input wire logic wbValid,
   input wire logic [31:0] wbStatusWord,
   output logic wbReady,
   // last word stored and word count
   output logic [31:0] gotWord,
   output logic [7:0] gotCount
);
   logic [2:0] waitCnt_r; // cycles the offer has waited
   // a slow host stalls so the offer must stand
   always @(posedge core_clk) begin
      if (sys_rst) begin
         wbReady <= 1'b0;
         waitCnt_r <= 3'h0;
         gotWord <= 32'h0;
         gotCount <= 8'h0;
      end else if (wbValid && wbReady) begin
         wbReady <= 1'b0;
         waitCnt_r <= 3'h0;
         gotWord <= wbStatusWord; // whole word with owner bit
         gotCount <= gotCount + 8'h1;
      end else if (wbValid) begin
         waitCnt_r <= waitCnt_r + 3'h1;
         wbReady <= !hostSlow || waitCnt_r == 3'h3;
      end
   end
endmodule
`default_nettype wire

/* File: dv/rdsw_status_writeback_chk.sv */
// rdsw_status_writeback_chk.sv: checks on the status word handoff.
// assumes: bound to the writeback block; one clock, sync reset.
`timescale 1ns/10ps
`default_nettype none
module rdsw_status_writeback_chk (
   // clock and reset
   input wire logic core_clk,
   input wire logic sys_rst,
   // word handoff
   input wire logic wbValid,
   input wire logic wbReady,
   input wire logic [31:0] wbStatusWord,
   input wire logic wbLast
);
   default clocking @(posedge core_clk); endclocking
   default disable iff (sys_rst);
   // ----
   // handoff steps
   // ----
   sequence offerSeq;
      wbValid && !wbReady;
   endsequence
   sequence takenSeq;
      wbValid && wbReady;
   endsequence
   own_clear_a:
      assert property (wbValid |-> !wbStatusWord[31]) else $error("owner bit set");
   esum_or_a:
      assert property (wbValid && wbLast |-> wbStatusWord[15] == |{wbStatusWord[14],
         wbStatusWord[11], wbStatusWord[7:6], wbStatusWord[1]}) else $error("summary wrong");
   last_mark_a:
      assert property (wbValid |-> wbStatusWord[8] == wbLast) else $error("last mark wrong");
   nobuf_len_a:
      assert property (wbValid && wbLast && wbStatusWord[14] |-> wbStatusWord[29:16] == 14'h0)
      else $error("length kept on no-buffer");
   runt_crc_a:
      assert property (wbValid && wbStatusWord[11] |-> !wbStatusWord[1]) else $error("crc on runt");
   legal_zero_a:
      assert property (wbValid && !wbStatusWord[11] && !wbStatusWord[7] |-> !wbStatusWord[0])
      else $error("bit 0 set");
   filter_len_a:
      assert property (wbValid && wbLast && wbStatusWord[30] && !wbStatusWord[14]
         |-> wbStatusWord[29:16] >= 14'h40) else $error("filter flag on short frame");
   word_hold_a:
      assert property (offerSeq |=> wbValid && $stable(wbStatusWord) && $stable(wbLast))
      else $error("offer changed before taken");
   take_drop_a:
      assert property (takenSeq |=> !wbValid) else $error("offer stays after take");
endmodule
bind rdsw_status_writeback rdsw_status_writeback_chk rdsw_status_writeback_chk_i (.*);
`default_nettype wire

/* File: dv/tb_rx_descriptor_status_writeback.sv */
// tb_rx_descriptor_status_writeback.sv: self-checking bench, frames and registers.
// assumes: host model answers word writes; registers on AXI4-Lite.
`timescale 1ns/10ps
`default_nettype none
module tb_rx_descriptor_status_writeback;
   logic core_clk, sys_rst, frameStart, byteStored, bufferFull, frameEnd, lenTypeValid;
   logic filterFail, multicastHit, collisionSeen, lateCollision, phyRxError, oddBits;
   logic crcBad, noBufferAvail, wbValid, wbReady, wbLast, irq, hostSlow, rxAll;
   logic [15:0] lenTypeField;
   logic [31:0] wbStatusWord, gotWord, s_axi_wdata, s_axi_rdata, rd, ew;
   logic [7:0] s_axi_awaddr, s_axi_araddr, gotCount, fl;
   logic [3:0] s_axi_wstrb;
   logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
   logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
   logic s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
   int errTotal, checksDone, k;
   // frame table: bytes, flags, byte after which buffers fill
   int nTab [8] = '{64, 64, 63, 1519, 200, 13, 40, 100};
   logic [7:0] fTab [8] = '{8'h01, 8'h01, 8'h41, 8'h32, 8'h84, 8'h08, 8'h40, 8'h40};
   int cTab [8] = '{-1, -1, -1, -1, -1, -1, 19, -1};
   assign {noBufferAvail, crcBad, oddBits, phyRxError, lateCollision, collisionSeen,
      multicastHit, filterFail} = fl;
   rdsw_status_writeback rdsw_status_writeback_i (.*);
   rdsw_host_mem rdsw_host_mem_i (.*);
   initial begin
      core_clk = 1'b0;
      forever #4 core_clk = ~core_clk;
   end
   // ----
   // expected word; runts also from collisions
   // ----
   function automatic logic [31:0] expw(input int n, input logic [7:0] f, input logic fs);
      logic runt;
      logic ov;
      runt = f[2] || n < 64;
      ov = n > 1518;
      expw = {1'b0, f[0] && rxAll && n >= 64, f[7] ? 14'h0 : 14'(n),
         (f[6] && !runt) || f[3] || ov || runt || f[7], f[7], 2'b0, runt, f[1], fs, 1'b1,
         ov, f[3], n >= 14 && lenTypeField > 16'h05dc, 1'b0, f[4], f[5], f[6] && !runt, 1'b0};
   endfunction
   task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
      checksDone++;
      if (got !== exp) begin
         errTotal++;
         $display("mismatch at %0t got %h exp %h", $time, got, exp);
      end
   endtask
   // bus tasks hold each channel until its ready edge
   task automatic axw(input logic [7:0] a, input logic [31:0] d);
      @(posedge core_clk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
      do begin
         @(posedge core_clk);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
      end while (!s_axi_bvalid);
      rsp = s_axi_bresp;
      s_axi_bready <= 1'b0;
   endtask
   task automatic axr(input logic [7:0] a);
      @(posedge core_clk);
      s_axi_araddr <= a;
      {s_axi_arvalid, s_axi_rready} <= 2'h3;
      do begin
         @(posedge core_clk);
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
      end while (!s_axi_rvalid);
      rd = s_axi_rdata;
      rsp = s_axi_rresp;
      s_axi_rready <= 1'b0;
   endtask
   // one frame; buffers may fill part way, then the frame goes on
   task automatic frame(input int n, input logic [7:0] f, input int cut);
      int i;
      logic [7:0] c0;
      frameStart <= 1'b1;
      @(posedge core_clk);
      {frameStart, lenTypeValid} <= 2'h1;
      fl <= f;
      for (i = 0; i < n; i++) begin
         byteStored <= 1'b1;
         @(posedge core_clk);
         lenTypeValid <= 1'b0;
         if (i == cut) begin
            c0 = gotCount;
            {byteStored, bufferFull} <= 2'h1;
            @(posedge core_clk);
            bufferFull <= 1'b0;
            while (gotCount == c0) @(posedge core_clk);
            cmp(gotWord & 32'h8000_0380, 32'h0000_0200);
         end
      end
      c0 = gotCount;
      {byteStored, frameEnd} <= 2'h1;
      @(posedge core_clk);
      frameEnd <= 1'b0;
      fl <= 8'h0;
      while (gotCount == c0) @(posedge core_clk);
      ew = expw(n, f, cut < 0);
      cmp(gotWord, ew);
   endtask
   task automatic endOfTest();
      if (errTotal == 0 && checksDone > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask
   initial begin
      {frameStart, byteStored, bufferFull, frameEnd, lenTypeValid, hostSlow, rxAll} = '0;
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
      {s_axi_awaddr, s_axi_araddr, s_axi_wdata, lenTypeField, fl} = '0;
      s_axi_wstrb = 4'hf;
      sys_rst = 1'b1;
      repeat (3) @(posedge core_clk);
      sys_rst <= 1'b0;
      axr(8'h08);
      cmp(rd, 32'h0);
      axw(8'h14, 32'h1);
      cmp(32'(rsp), 32'h2);
      for (k = 0; k < 8; k++) begin
         hostSlow <= k[0];
         lenTypeField <= k[0] ? 16'h05dc : 16'h0600;
         frame(nTab[k], fTab[k], cTab[k]);
         axr(8'h04);
         cmp(rd, {30'h0, ew[15], 1'b1});
         cmp(32'(irq), 32'(k != 0));
         axw(8'h04, 32'h3);
         axr(8'h0c);
         cmp(rd, ew);
         cmp(32'(irq), 32'h0);
         if (k == 0) begin
            axw(8'h00, 32'h1);
            rxAll = 1'b1;
            axw(8'h08, 32'h3);
         end
      end
      axr(8'h10);
      cmp(rd, 32'h8);
      axr(8'h14);
      cmp({rd[29:0], rsp}, 32'h2);
      endOfTest();
   end
   // cut a hang short
   initial begin
      #100000;
      errTotal++;
      endOfTest();
   end
endmodule
`default_nettype wire

/* File: hw/rdsw_status_writeback.v */
// rdsw_status_writeback.v: builds the receive descriptor status word and
// hands it to the descriptor DMA as one 32-bit write.
// assumes: frame events come from receive logic on core_clk; the dma side
// holds wbReady low while busy; software on AXI4-Lite sets receive-all.
//
// Local design decisions: the register addresses and register access over AXI4-Lite.
`timescale 1ns/10ps
`default_nettype none
`include "rdsw_defs.vh"

// Overview of operation
// - bit 31 is ownership, 1 engine
// - clear ownership at frame end or buffer full
// - bit 30 filter fail, last, receive-all, >=64
// - bits 29:16 byte count, last and no-buffer clear
// - bit 15 ORs bits 1,6,7,11,14
// - bit 14 no host buffer available
// - bit 11 collision or premature end
// - bit 10 multicast destination
// - bit 9 only in first descriptor
// - bit 8 only in last descriptor
// - bit 7 oversize, valid every descriptor
// - bit 6 late collision after 64 bytes
// - bit 5 length/type field above 1500
// - bit 3 phy signalled receive error
// - bit 2 frame not byte aligned
// - bit 1 bad frame check, not runts
// - bit 0 zero for legal length
module rdsw_status_writeback (
   // clock and reset
   input wire core_clk,
   input wire sys_rst,
   // receive engine events, same clock
   input wire frameStart,
   input wire byteStored,
   input wire bufferFull,
   input wire frameEnd,
   input wire [15:0] lenTypeField,
   input wire lenTypeValid,
   input wire filterFail,
   input wire multicastHit,
   input wire collisionSeen,
   input wire lateCollision,
   input wire phyRxError,
   input wire oddBits,
   input wire crcBad,
   input wire noBufferAvail,
   // writeback request to descriptor dma
   output wire wbValid,
   input wire wbReady,
   output reg [31:0] wbStatusWord,
   output reg wbLast,
   // AXI4-Lite slave
   input wire [7:0] s_axi_awaddr,
   input wire s_axi_awvalid,
   output wire s_axi_awready,
   input wire [31:0] s_axi_wdata,
   input wire [3:0] s_axi_wstrb,
   input wire s_axi_wvalid,
   output wire s_axi_wready,
   output reg [1:0] s_axi_bresp,
   output reg s_axi_bvalid,
   input wire s_axi_bready,
   input wire [7:0] s_axi_araddr,
   input wire s_axi_arvalid,
   output wire s_axi_arready,
   output reg [31:0] s_axi_rdata,
   output reg [1:0] s_axi_rresp,
   output reg s_axi_rvalid,
   input wire s_axi_rready,
   // interrupt
   output wire irq
);

   // ----------------------------------------------------------------------
   // state
   // ----------------------------------------------------------------------
   localparam [1:0] ST_IDLE = 2'h0; // no frame
   localparam [1:0] ST_RECV = 2'h1; // filling a descriptor
   localparam [1:0] ST_WAIT = 2'h2; // word offered to dma

   reg [1:0] state_r; // main sequencer
   reg inFirst_r; // current descriptor holds the frame start
   reg [13:0] byteCnt_r; // bytes moved to host for this frame
   reg oversize_r; // sticky over the whole frame
   reg filt_r, mcast_r, coll_r, late_r, phy_r, odd_r, crc_r, nobuf_r;
   reg [15:0] lenType_r; // captured length/type field
   reg ltSeen_r; // length/type field captured
   reg wbValid_r; // offer pending
   reg recvAll_r; // receive-all mode from software
   reg [1:0] stat_r; // interrupt status
   reg [1:0] mask_r; // interrupt mask
   reg [31:0] lastWord_r; // last word written back, for software
   reg [15:0] frameCnt_r; // completed frames

   // ----------------------------------------------------------------------
   // status word composer, used for both kinds of descriptor
   // ----------------------------------------------------------------------
   function [31:0] build_word;
      input isLast;
      input isFirst;
      input [13:0] cnt;
      input over;
      reg [31:0] w;
      reg runt;
      reg errSum;
      begin
         w = 32'h0000_0000;
         runt = coll_r | (cnt < `RDSW_MIN_FILT_LEN);
         w[`RDSW_OWN_BIT] = 1'b0; // returned to host
         w[`RDSW_FIRST_BIT] = isFirst;
         w[`RDSW_OVER_BIT] = over; // kept in every descriptor
         if (isLast) begin
            w[`RDSW_LAST_BIT] = 1'b1;
            // failure only meaningful with receive-all and full size
            w[`RDSW_FILT_BIT] = filt_r & recvAll_r & (cnt >= `RDSW_MIN_FILT_LEN);
            w[`RDSW_LEN_HI:`RDSW_LEN_LO] = nobuf_r ? 14'h0000 : cnt;
            w[`RDSW_NOBUF_BIT] = nobuf_r;
            w[`RDSW_SHORT_BIT] = runt;
            w[`RDSW_MCAST_BIT] = mcast_r;
            w[`RDSW_LATE_BIT] = late_r;
            // type flag left clear when too short to hold the field
            w[`RDSW_TYPE_BIT] = ltSeen_r & (cnt >= `RDSW_MIN_TYPE_LEN) &
                                (lenType_r > `RDSW_MAX_LEN_FIELD);
            w[`RDSW_PHY_BIT] = phy_r;
            w[`RDSW_ODD_BIT] = odd_r;
            w[`RDSW_CRC_BIT] = crc_r & ~runt;
            errSum = w[`RDSW_CRC_BIT] | w[`RDSW_LATE_BIT] | over |
                     w[`RDSW_SHORT_BIT] | w[`RDSW_NOBUF_BIT];
            w[`RDSW_ESUM_BIT] = errSum;
         end
         w[`RDSW_ZERO_BIT] = 1'b0;
         build_word = w;
      end
   endfunction

   // ----------------------------------------------------------------------
   // frame tracking and writeback sequencer
   // ----------------------------------------------------------------------
   wire [13:0] cntNext = byteCnt_r + {13'h0000, byteStored};
   wire overNext = oversize_r | (cntNext > `RDSW_MAX_FRAME_LEN);
   wire wbTake = wbValid_r & wbReady;
   assign wbValid = wbValid_r;

   // the whole word, ownership included, is latched once and offered as
   // a single transfer so the host never sees a half-updated word
   always @(posedge core_clk) begin
      if (sys_rst) begin
         state_r <= ST_IDLE;
         inFirst_r <= 1'b0;
         byteCnt_r <= 14'h0000;
         oversize_r <= 1'b0;
         {filt_r, mcast_r, coll_r, late_r, phy_r, odd_r, crc_r, nobuf_r} <= 8'h00;
         lenType_r <= 16'h0000;
         ltSeen_r <= 1'b0;
         wbValid_r <= 1'b0;
         wbStatusWord <= 32'h0000_0000;
         wbLast <= 1'b0;
      end else begin
         case (state_r)
            ST_IDLE: begin
               // a new frame resets the per-frame flags
               if (frameStart) begin
                  state_r <= ST_RECV;
                  inFirst_r <= 1'b1;
                  byteCnt_r <= 14'h0000;
                  oversize_r <= 1'b0;
                  {filt_r, mcast_r, coll_r, late_r, phy_r, odd_r, crc_r, nobuf_r} <= 8'h00;
                  ltSeen_r <= 1'b0;
               end
            end
            ST_RECV: begin
               byteCnt_r <= cntNext;
               oversize_r <= overNext;
               filt_r <= filt_r | filterFail;
               mcast_r <= mcast_r | multicastHit;
               coll_r <= coll_r | collisionSeen;
               late_r <= late_r | lateCollision;
               phy_r <= phy_r | phyRxError;
               odd_r <= odd_r | oddBits;
               crc_r <= crc_r | crcBad;
               nobuf_r <= nobuf_r | noBufferAvail;
               if (lenTypeValid) begin
                  lenType_r <= lenTypeField;
                  ltSeen_r <= 1'b1;
               end
               if (frameEnd) begin
                  // last descriptor of the frame
                  wbStatusWord <= build_word(1'b1, inFirst_r, cntNext, overNext);
                  wbLast <= 1'b1;
                  wbValid_r <= 1'b1;
                  state_r <= ST_WAIT;
               end else if (bufferFull) begin
                  // buffers full mid-frame: hand back an intermediate one
                  wbStatusWord <= build_word(1'b0, inFirst_r, cntNext, overNext);
                  wbLast <= 1'b0;
                  wbValid_r <= 1'b1;
                  state_r <= ST_WAIT;
               end
            end
            ST_WAIT: begin
               // receive engine is expected to pause until the word is taken
               if (wbTake) begin
                  wbValid_r <= 1'b0;
                  inFirst_r <= 1'b0; // later descriptors are not first
                  state_r <= wbLast ? ST_IDLE : ST_RECV;
               end
            end
            default: state_r <= ST_IDLE;
         endcase
      end
   end

   // ----------------------------------------------------------------------
   // AXI4-Lite write path: address and data taken in either order
   // ----------------------------------------------------------------------
   reg awHave_r, wHave_r;
   reg [7:0] awAddr_r;
   reg [31:0] wData_r;
   assign s_axi_awready = ~awHave_r & ~s_axi_bvalid;
   assign s_axi_wready = ~wHave_r & ~s_axi_bvalid;
   wire doWrite = awHave_r & wHave_r & ~s_axi_bvalid;

   // events raised by the writeback: done per taken word, error on an
   // errored last word
   wire evDone = wbTake;
   wire evErr = wbTake & wbLast & wbStatusWord[`RDSW_ESUM_BIT];
   wire wrStat = doWrite & (awAddr_r == `RDSW_ADDR_STAT);

   always @(posedge core_clk) begin
      if (sys_rst) begin
         awHave_r <= 1'b0;
         wHave_r <= 1'b0;
         awAddr_r <= 8'h00;
         wData_r <= 32'h0000_0000;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= `RDSW_AXI_OKAY;
         recvAll_r <= 1'b0;
         mask_r <= `RDSW_MASK_RST;
      end else begin
         if (s_axi_awvalid & s_axi_awready) begin
            awHave_r <= 1'b1;
            awAddr_r <= s_axi_awaddr;
         end
         if (s_axi_wvalid & s_axi_wready) begin
            wHave_r <= 1'b1;
            wData_r <= s_axi_wdata;
         end
         if (doWrite) begin
            awHave_r <= 1'b0;
            wHave_r <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= `RDSW_AXI_OKAY;
            // control: bit 0 is receive-all
            if (awAddr_r == `RDSW_ADDR_CTRL) begin
               recvAll_r <= wData_r[0];
            end else if (awAddr_r == `RDSW_ADDR_MASK) begin
               mask_r <= wData_r[1:0];
            end else if (awAddr_r == `RDSW_ADDR_STAT || awAddr_r == `RDSW_ADDR_LAST ||
                         awAddr_r == `RDSW_ADDR_CNT) begin
               s_axi_bresp <= `RDSW_AXI_OKAY; // read-only or w1c, accepted
            end else begin
               s_axi_bresp <= `RDSW_AXI_SLVERR; // unmapped
            end
         end else if (s_axi_bvalid & s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   // ----------------------------------------------------------------------
   // interrupt status: set wins over write-one-to-clear
   // ----------------------------------------------------------------------
   always @(posedge core_clk) begin
      if (sys_rst) begin
         stat_r <= 2'h0;
         lastWord_r <= 32'h0000_0000;
         frameCnt_r <= 16'h0000;
      end else begin
         stat_r <= (stat_r & ~({2{wrStat}} & wData_r[1:0])) | {evErr, evDone};
         if (wbTake) begin
            lastWord_r <= wbStatusWord;
         end
         if (wbTake & wbLast) begin
            frameCnt_r <= frameCnt_r + 16'h0001;
         end
      end
   end
   assign irq = |(stat_r & mask_r);

   // ----------------------------------------------------------------------
   // AXI4-Lite read path: one cycle to rvalid
   // ----------------------------------------------------------------------
   assign s_axi_arready = ~s_axi_rvalid;

   always @(posedge core_clk) begin
      if (sys_rst) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0000_0000;
         s_axi_rresp <= `RDSW_AXI_OKAY;
      end else if (s_axi_arvalid & s_axi_arready) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rresp <= `RDSW_AXI_OKAY;
         if (s_axi_araddr == `RDSW_ADDR_CTRL) begin
            s_axi_rdata <= {31'h0000_0000, recvAll_r};
         end else if (s_axi_araddr == `RDSW_ADDR_STAT) begin
            s_axi_rdata <= {30'h0000_0000, stat_r};
         end else if (s_axi_araddr == `RDSW_ADDR_MASK) begin
            s_axi_rdata <= {30'h0000_0000, mask_r};
         end else if (s_axi_araddr == `RDSW_ADDR_LAST) begin
            s_axi_rdata <= lastWord_r;
         end else if (s_axi_araddr == `RDSW_ADDR_CNT) begin
            s_axi_rdata <= {16'h0000, frameCnt_r};
         end else begin
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= `RDSW_AXI_SLVERR;
         end
      end else if (s_axi_rvalid & s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end

endmodule
`default_nettype wire

/* File: pkg/rdsw_defs.vh */
// rdsw_defs.vh: constants for the receive descriptor status writeback block.
// assumes: included by bare name from the design file; the bench files do not include it.
`ifndef RDSW_DEFS_VH
`define RDSW_DEFS_VH

// ----------------------------------------------------------------------
// status word field positions
// ----------------------------------------------------------------------
`define RDSW_OWN_BIT 31
`define RDSW_FILT_BIT 30
`define RDSW_LEN_HI 29
`define RDSW_LEN_LO 16
`define RDSW_ESUM_BIT 15
`define RDSW_NOBUF_BIT 14
`define RDSW_SHORT_BIT 11
`define RDSW_MCAST_BIT 10
`define RDSW_FIRST_BIT 9
`define RDSW_LAST_BIT 8
`define RDSW_OVER_BIT 7
`define RDSW_LATE_BIT 6
`define RDSW_TYPE_BIT 5
`define RDSW_PHY_BIT 3
`define RDSW_ODD_BIT 2
`define RDSW_CRC_BIT 1
`define RDSW_ZERO_BIT 0

// ----------------------------------------------------------------------
// frame size thresholds (bytes)
// ----------------------------------------------------------------------
`define RDSW_MIN_FILT_LEN 14'h0040
`define RDSW_MAX_FRAME_LEN 14'h05ee
`define RDSW_MAX_LEN_FIELD 16'h05dc
`define RDSW_MIN_TYPE_LEN 14'h000e

// ----------------------------------------------------------------------
// register map (byte addresses) and reset values
// ----------------------------------------------------------------------
`define RDSW_ADDR_CTRL 8'h00
`define RDSW_ADDR_STAT 8'h04
`define RDSW_ADDR_MASK 8'h08
`define RDSW_ADDR_LAST 8'h0c
`define RDSW_ADDR_CNT 8'h10
`define RDSW_CTRL_RST 32'h0000_0000
`define RDSW_MASK_RST 2'h0
`define RDSW_AXI_OKAY 2'h0
`define RDSW_AXI_SLVERR 2'h2

// ----------------------------------------------------------------------
// interrupt status bits
// ----------------------------------------------------------------------
`define RDSW_IRQ_DONE 0
`define RDSW_IRQ_ERR 1

`endif
